// ### trigger_unit_pkg.sv
// Functional notes
// - mask bit 1 enables its source
// - reported status shows only enabled pending bits
// - masked-off events still captured in shared hardware
// - blocking status read waits for enabled event
// - read word: kicks upper, triggers lower half
// - blocking read takes one kick when bit 1 is enabled, unless timer is visible
// - status write: ones clear, zeros keep
// - status writes never alter kick count
// - clear of bits 15 to 0 only where thread mask bit set, bits 23 to 16 clear unmasked
// - poll view answers at once, same format
// - poll never takes a kick
// - each kick write adds one kick, until the count saturates at all ones
// - separate kick counter per thread
// - thread timer events appear at bit 0
// - bits 15 to 4 carry hardware triggers
// - bus error state 31:24, flag 23, 22 zero
// - bits 21 to 16 carry float flags
// - bit 3 is deferred exception level
// - bit 1 is kick count non-zero level
// - bit 2 halt only at interrupt level
// - mask bits 31 to 16 read zero
// - blocking read with empty mask raises exception
package trigger_unit_pkg;

  // ==========================================================
  // sizes
  // ==========================================================
  localparam int unsigned THREAD_IDX_W = 2; // width of a thread index
  localparam int unsigned KICK_W = 16; // kick counter width, fills the upper half word
  localparam int unsigned NUM_LEVELS = 2; // background and interrupt level

  // ==========================================================
  // processing levels
  // ==========================================================
  localparam logic LVL_BG = 1'b0; // background level
  localparam logic LVL_INT = 1'b1; // interrupt level

  // ==========================================================
  // status and mask bit positions
  // ==========================================================
  localparam int unsigned BIT_TIMER = 0; // timer trigger
  localparam int unsigned BIT_KICK = 1; // kick count non-zero
  localparam int unsigned BIT_HALT = 2; // background halt, interrupt level only
  localparam int unsigned BIT_DEFEXC = 3; // deferred exception level
  localparam int unsigned HW_LO = 4; // lowest hardware trigger
  localparam int unsigned HW_HI = 15; // highest hardware trigger
  localparam int unsigned FP_LO = 16; // float inexact
  localparam int unsigned FP_HI = 21; // float denormal
  localparam int unsigned BIT_ZERO = 22; // always zero
  localparam int unsigned BIT_BUSERR = 23; // deferred bus error / test and set
  localparam int unsigned BERR_LO = 24; // bus error state low bit
  localparam int unsigned BERR_HI = 31; // bus error state high bit

  // ==========================================================
  // reset values
  // ==========================================================
  localparam logic [15:0] MASK_RESET = 16'h0000; // all sources disabled
  localparam logic [31:0] STAT_RESET = 32'h0000_0000; // nothing pending
  localparam logic [15:0] HW_RESET = 16'h0000; // no shared hardware events
  localparam logic [15:0] MASK_RSVD = 16'h0000; // upper mask half word

  // ==========================================================
  // register selection and carriers
  // ==========================================================
  // trigger_status_clear, trigger_poll_view, trigger_enable_mask
  typedef enum logic [1:0] {SEL_STATUS, SEL_POLL, SEL_MASK} reg_sel_e;

  // register transfer from a thread
  typedef struct packed {
    logic valid;
    logic write;
    logic level;
    logic [THREAD_IDX_W-1:0] thread;
    reg_sel_e sel;
    logic [31:0] wdata;
  } reg_req_s;

  // answer to a register read
  typedef struct packed {
    logic valid;
    logic exc;
    logic [THREAD_IDX_W-1:0] thread;
    logic [31:0] rdata;
  } reg_rsp_s;

  // write to a memory mapped kick counter
  typedef struct packed {
    logic valid;
    logic level;
    logic [THREAD_IDX_W-1:0] thread;
  } kick_req_s;

endpackage

// ### kick_counter.sv
`timescale 1ns/1ps
`default_nettype none
module kick_counter
  import trigger_unit_pkg::*;
#(
  parameter int unsigned WIDTH = trigger_unit_pkg::KICK_W
)(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic inc,
  input wire logic dec,
  output logic [WIDTH-1:0] count,
  output logic nonzero
);

  // ==========================================================
  // accumulating kick count
  // ==========================================================
  localparam logic [WIDTH-1:0] ONE = {{(WIDTH-1){1'b0}}, 1'b1}; // unit step
  localparam logic [WIDTH-1:0] FULL = {WIDTH{1'b1}}; // saturation value

  logic do_inc; // add a kick
  logic do_dec; // take a kick

  // simultaneous add and take cancel out
  assign do_inc = inc && !dec && (count != FULL);
  assign do_dec = dec && !inc && (count != '0);

  // counter, saturating so a flood of kicks never wraps to zero
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      count <= '0;
    else if (do_inc)
      count <= count + ONE;
    else if (do_dec)
      count <= count - ONE;
  end

  // level view of a pending kick
  assign nonzero = (count != '0);

endmodule
`default_nettype wire

// ### trigger_unit.sv
`timescale 1ns/1ps
`default_nettype none
module thread_background_trigger_unit #(
  parameter int unsigned NUM_THREADS = 4
)(
  input wire logic ref_clk,
  input wire logic sys_rst,
  // register transfers from the threads
  input wire trigger_unit_pkg::reg_req_s req,
  output logic req_ready,
  output trigger_unit_pkg::reg_rsp_s rsp,
  // kick counter writes
  input wire trigger_unit_pkg::kick_req_s kick,
  // hardware trigger pins, asynchronous
  input wire logic [trigger_unit_pkg::HW_HI:trigger_unit_pkg::HW_LO] hw_trigger,
  // per-thread timer pulses, index 0 background, 1 interrupt
  input wire logic [NUM_THREADS-1:0][1:0] timer_event,
  // per-thread float flag pulses, bit 5 denormal down to bit 0 inexact
  input wire logic [NUM_THREADS-1:0][5:0] fp_event,
  // per-thread deferred bus error pulses
  input wire logic [NUM_THREADS-1:0] bus_err_event,
  // per-thread deferred bus error state, level
  input wire logic [NUM_THREADS-1:0][7:0] bus_err_state,
  // per-thread deferred exception condition, level
  input wire logic [NUM_THREADS-1:0] def_exc,
  // per-thread background halt pulses
  input wire logic [NUM_THREADS-1:0] halt_event,
  // per-thread kick counts, background level
  output logic [NUM_THREADS-1:0][trigger_unit_pkg::KICK_W-1:0] bg_kick_count,
  // per-thread deferred state, status bits 31 to 16 of background level
  output logic [NUM_THREADS-1:0][15:0] deferred_view
);
  import trigger_unit_pkg::*;

  // ==========================================================
  // helper functions
  // ==========================================================
  // status as a thread sees it through its mask
  function automatic logic [31:0] visible(input logic [31:0] raw, input logic [15:0] msk);
    return {raw[31:16], raw[15:0] & msk};
  endfunction

  // read word, kick count high and trigger status low
  function automatic logic [31:0] read_word(input logic [KICK_W-1:0] kc,
                                            input logic [31:0] vis);
    return {kc, vis[15:0]};
  endfunction

  // a visible enabled trigger releases a blocking read
  function automatic logic released(input logic [31:0] raw, input logic [15:0] msk);
    return |(raw[15:0] & msk);
  endfunction

  // ==========================================================
  // storage
  // ==========================================================
  logic [2:0][HW_HI:HW_LO] hw_sync; // pin synchroniser and change detector
  logic [HW_HI:HW_LO] hw_change; // change of state on a pin
  logic [HW_HI:HW_LO] hw_pend; // shared hardware pending bits
  logic [HW_HI:HW_LO] hw_clear; // clears from all threads this cycle
  logic [15:0] mask_q [NUM_THREADS][NUM_LEVELS]; // trigger enable masks
  logic [31:0] stat_q [NUM_THREADS][NUM_LEVELS]; // independent pending bits
  logic [31:0] raw [NUM_THREADS][NUM_LEVELS]; // full unmasked status
  logic [31:0] vis [NUM_THREADS][NUM_LEVELS]; // masked status
  logic cond [NUM_THREADS][NUM_LEVELS]; // release condition
  logic take [NUM_THREADS][NUM_LEVELS]; // a kick may be taken now
  logic [KICK_W-1:0] kcount [NUM_THREADS][NUM_LEVELS]; // kick counts
  logic knz [NUM_THREADS][NUM_LEVELS]; // kick count non-zero
  logic park [NUM_THREADS]; // thread descheduled on blocking read
  logic park_lvl [NUM_THREADS]; // level of the parked read

  // ==========================================================
  // request decode
  // ==========================================================
  logic req_ok; // request taken this cycle
  logic req_thr_ok; // thread index in range
  logic rd_status; // blocking read taken
  logic rd_now; // blocking read satisfied at once
  logic rd_exc; // blocking read with an empty mask
  logic wr_status; // status clear write
  logic wr_mask; // mask write
  logic rel_any; // some parked thread is released
  logic [THREAD_IDX_W-1:0] rel_t; // released thread
  logic serve; // a blocking read completes this cycle
  logic [THREAD_IDX_W-1:0] serve_t; // thread completing
  logic serve_l; // its level

  assign req_thr_ok = (32'(req.thread) < NUM_THREADS);
  assign req_ok = req.valid && req_ready && req_thr_ok;
  assign rd_status = req_ok && !req.write && (req.sel == SEL_STATUS);
  assign rd_exc = rd_status && (mask_q[req.thread][req.level] == '0);
  assign rd_now = rd_status && !rd_exc && cond[req.thread][req.level];
  assign wr_status = req_ok && req.write && (req.sel == SEL_STATUS);
  assign wr_mask = req_ok && req.write && (req.sel == SEL_MASK);

  // parked releases take the answer slot, so new requests wait
  assign req_ready = !rel_any;

  // lowest numbered parked thread whose condition holds
  always_comb
  begin
    rel_any = 1'b0;
    rel_t = '0;
    for (int t = NUM_THREADS - 1; t >= 0; t--)
    begin
      if (park[t] && cond[t][park_lvl[t]])
      begin
        rel_any = 1'b1;
        rel_t = THREAD_IDX_W'(t);
      end
    end
  end

  // the one blocking read that completes this cycle
  always_comb
  begin
    serve = rel_any || rd_now;
    serve_t = rel_any ? rel_t : req.thread;
    serve_l = rel_any ? park_lvl[rel_t] : req.level;
  end

  // ==========================================================
  // hardware trigger pins
  // ==========================================================
  // two flops for the crossing, a third to spot a change
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      hw_sync <= '0;
    else
      hw_sync <= {hw_sync[1:0], hw_trigger};
  end

  assign hw_change = hw_sync[2] ^ hw_sync[1];

  // clears from any thread whose mask enables the bit
  always_comb
  begin
    hw_clear = '0;
    if (wr_status)
      hw_clear = req.wdata[HW_HI:HW_LO] & mask_q[req.thread][req.level][HW_HI:HW_LO];
  end

  // shared pending bits, captured whatever the masks say
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      hw_pend <= HW_RESET[HW_HI:HW_LO];
    else
      hw_pend <= (hw_pend & ~hw_clear) | hw_change;
  end

  // ==========================================================
  // per thread and level state
  // ==========================================================
  genvar gt;
  genvar gl;
  generate
    for (gt = 0; gt < NUM_THREADS; gt++)
    begin : g_thr
      for (gl = 0; gl < NUM_LEVELS; gl++)
      begin : g_lvl
        logic sel_here; // request addresses this thread and level
        logic [31:0] set_bits; // events arriving this cycle
        logic [31:0] clr_bits; // acknowledged bits
        logic kick_inc; // kick write to this counter
        logic kick_dec; // kick taken by a blocking read

        assign sel_here = (req.thread == THREAD_IDX_W'(gt)) && (req.level == gl[0]);

        // mask register
        always_ff @(posedge ref_clk)
        begin
          if (sys_rst)
            mask_q[gt][gl] <= MASK_RESET;
          else if (wr_mask && sel_here)
          begin
            mask_q[gt][gl] <= req.wdata[15:0];
            if (gl == 0)
              mask_q[gt][gl][BIT_HALT] <= 1'b0;
          end
        end

        // events landing in the independent bits
        always_comb
        begin
          set_bits = '0;
          set_bits[BIT_TIMER] = timer_event[gt][gl];
          set_bits[FP_HI:FP_LO] = fp_event[gt];
          set_bits[BIT_BUSERR] = bus_err_event[gt];
          set_bits[BIT_HALT] = (gl == 1) ? halt_event[gt] : 1'b0;
        end

        // acknowledge pattern, only edge captured bits can clear
        always_comb
        begin
          clr_bits = '0;
          if (wr_status && sel_here)
          begin
            clr_bits[BIT_TIMER] = req.wdata[BIT_TIMER] & mask_q[gt][gl][BIT_TIMER];
            clr_bits[BIT_HALT] = req.wdata[BIT_HALT] & mask_q[gt][gl][BIT_HALT];
            clr_bits[BIT_BUSERR:FP_LO] = req.wdata[BIT_BUSERR:FP_LO];
          end
        end

        // independent pending bits
        always_ff @(posedge ref_clk)
        begin
          if (sys_rst)
            stat_q[gt][gl] <= STAT_RESET;
          // events win over a same cycle clear
          else
            stat_q[gt][gl] <= (stat_q[gt][gl] & ~clr_bits) | set_bits;
        end

        // full status word before masking
        always_comb
        begin
          raw[gt][gl] = stat_q[gt][gl];
          raw[gt][gl][BERR_HI:BERR_LO] = bus_err_state[gt];
          raw[gt][gl][BIT_ZERO] = 1'b0;
          raw[gt][gl][HW_HI:HW_LO] = hw_pend;
          raw[gt][gl][BIT_DEFEXC] = def_exc[gt];
          raw[gt][gl][BIT_KICK] = knz[gt][gl];
        end

        assign vis[gt][gl] = visible(raw[gt][gl], mask_q[gt][gl]);
        assign cond[gt][gl] = released(raw[gt][gl], mask_q[gt][gl]);
        assign take[gt][gl] = mask_q[gt][gl][BIT_KICK] && knz[gt][gl] &&
                              !vis[gt][gl][BIT_TIMER];

        assign kick_inc = kick.valid && (kick.thread == THREAD_IDX_W'(gt)) &&
                          (kick.level == gl[0]);
        assign kick_dec = serve && (serve_t == THREAD_IDX_W'(gt)) &&
                          (serve_l == gl[0]) && take[gt][gl];

        kick_counter #(
          .WIDTH(KICK_W)
        ) u_kick (
          .ref_clk(ref_clk),
          .sys_rst(sys_rst),
          .inc(kick_inc),
          .dec(kick_dec),
          .count(kcount[gt][gl]),
          .nonzero(knz[gt][gl])
        );
      end

      // background level views for the core
      assign bg_kick_count[gt] = kcount[gt][0];
      assign deferred_view[gt] = raw[gt][0][31:16];

      // descheduled thread tracking
      always_ff @(posedge ref_clk)
      begin
        if (sys_rst)
        begin
          park[gt] <= 1'b0;
          park_lvl[gt] <= LVL_BG;
        end
        else if (rd_status && !rd_exc && !rd_now && (req.thread == THREAD_IDX_W'(gt)))
        begin
          park[gt] <= 1'b1;
          park_lvl[gt] <= req.level;
        end
        else if (rel_any && (rel_t == THREAD_IDX_W'(gt)))
          park[gt] <= 1'b0;
      end
    end
  endgenerate

  // ==========================================================
  // answer register
  // ==========================================================
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      rsp <= '0;
    else
    begin
      rsp.valid <= 1'b0;
      rsp.exc <= 1'b0;
      if (serve)
      begin
        // completed blocking read, value before the kick is taken
        rsp.valid <= 1'b1;
        rsp.thread <= serve_t;
        rsp.rdata <= read_word(kcount[serve_t][serve_l], vis[serve_t][serve_l]);
      end
      else if (rd_exc)
      begin
        rsp.valid <= 1'b1;
        rsp.exc <= 1'b1;
        rsp.thread <= req.thread;
        rsp.rdata <= '0;
      end
      else if (req_ok && !req.write && (req.sel == SEL_POLL))
      begin
        rsp.valid <= 1'b1;
        rsp.thread <= req.thread;
        rsp.rdata <= read_word(kcount[req.thread][req.level], vis[req.thread][req.level]);
      end
      else if (req_ok && !req.write && (req.sel == SEL_MASK))
      begin
        rsp.valid <= 1'b1;
        rsp.thread <= req.thread;
        rsp.rdata <= {MASK_RSVD, mask_q[req.thread][req.level]};
      end
    end
  end

endmodule
`default_nettype wire

// ### trigger_unit_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port checker for the trigger unit
// ==========================================================
module trigger_unit_chk
  import trigger_unit_pkg::*;
#(
  parameter int unsigned NUM_THREADS = 4
)(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire trigger_unit_pkg::reg_req_s req,
  input wire logic req_ready,
  input wire trigger_unit_pkg::reg_rsp_s rsp,
  input wire trigger_unit_pkg::kick_req_s kick,
  input wire logic [NUM_THREADS-1:0][5:0] fp_event,
  input wire logic [NUM_THREADS-1:0] bus_err_event,
  input wire logic [NUM_THREADS-1:0][7:0] bus_err_state,
  input wire logic [NUM_THREADS-1:0][trigger_unit_pkg::KICK_W-1:0] bg_kick_count,
  input wire logic [NUM_THREADS-1:0][15:0] deferred_view
);
  // one clock domain, reset masks every check
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  // a read request that never parks
  wire logic quick_rd = req.valid && req_ready && !req.write && req.sel != SEL_STATUS;
  a_poll_answer_next: assert property (quick_rd |=> rsp.valid && !rsp.exc
    && rsp.thread == $past(req.thread)) else $error("quick read not answered in one cycle");
  a_mask_upper_zero: assert property (quick_rd && req.sel == SEL_MASK
    |=> rsp.rdata[31:16] == 16'h0000) else $error("mask read upper half not zero");
  a_kick_add_one: assert property (bg_kick_count[0] > $past(bg_kick_count[0])
    |-> bg_kick_count[0] == $past(bg_kick_count[0]) + 16'h0001
    && $past(kick.valid && kick.thread == 2'd0 && kick.level == LVL_BG))
    else $error("kick count rose without one kick write");
  a_kick_take_read: assert property (bg_kick_count[0] < $past(bg_kick_count[0])
    |-> rsp.valid && rsp.thread == 2'd0 && !rsp.exc
    && bg_kick_count[0] == $past(bg_kick_count[0]) - 16'h0001)
    else $error("kick count fell without a status answer");
  a_berr_state_live: assert property (deferred_view[0][15:8] == bus_err_state[0]
    && deferred_view[0][6] == 1'b0) else $error("bus error state or zero bit wrong");
  a_fp_flag_set: assert property (|fp_event[0] |=>
    (deferred_view[0][5:0] & $past(fp_event[0])) == $past(fp_event[0]))
    else $error("float flag not captured");
  a_berr_flag_set: assert property (bus_err_event[0] |=> deferred_view[0][7])
    else $error("bus error flag not captured");
  a_reset_clears: assert property ($fell(sys_rst) |-> bg_kick_count == '0
    && !rsp.valid && req_ready) else $error("state not cleared by reset");
endmodule
bind thread_background_trigger_unit trigger_unit_chk #(.NUM_THREADS(NUM_THREADS)) chk_u (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .req(req), .req_ready(req_ready), .rsp(rsp),
  .kick(kick), .fp_event(fp_event), .bus_err_event(bus_err_event),
  .bus_err_state(bus_err_state), .bg_kick_count(bg_kick_count), .deferred_view(deferred_view)
);
`default_nettype wire

// ### hw_trigger_source.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// external hardware trigger sources
// ==========================================================
module hw_trigger_source (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [15:4] flip_req,
  output logic [15:4] hw_pin
);
  // flags start low
  initial hw_pin = 12'h000;
  // flag flips are events
  // flips land well after the edge, like an unrelated source
  always @(posedge ref_clk)
  begin
    if (sys_rst)
      hw_pin <= #37 12'h000;
    else if (|flip_req)
      hw_pin <= #37 hw_pin ^ flip_req;
  end
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import trigger_unit_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  // ==========================================================
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  reg_req_s req = '0;
  kick_req_s kick = '0;
  logic req_ready;
  reg_rsp_s rsp;
  logic [15:4] flip_req = '0;
  logic [15:4] hw_trigger;
  logic [3:0][1:0] timer_event = '0;
  logic [3:0][5:0] fp_event = '0;
  logic [3:0] bus_err_event = '0;
  logic [3:0][7:0] bus_err_state = '0;
  logic [3:0] def_exc = '0;
  logic [3:0] halt_event = '0;
  logic [3:0][15:0] bg_kick_count;
  logic [3:0][15:0] deferred_view;
  int error_cnt = 0;
  int check_count = 0;
  // bench model: kicks, masks, timer and shared hardware pending bits
  int kq[4] = '{default: 0};
  logic [15:0] msk[4] = '{default: 16'h0000};
  logic [15:0] tmr[4] = '{default: 16'h0000};
  logic [15:0] hwp = 16'h0000;
  logic [31:0] rd;
  logic ex;
  int n;
  logic lv = LVL_BG; // processing level used by the request task

  // clock
  always #50 ref_clk = ~ref_clk;

  thread_background_trigger_unit #(.NUM_THREADS(4)) dut_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .req(req), .req_ready(req_ready), .rsp(rsp),
    .kick(kick), .hw_trigger(hw_trigger), .timer_event(timer_event), .fp_event(fp_event),
    .bus_err_event(bus_err_event), .bus_err_state(bus_err_state), .def_exc(def_exc),
    .halt_event(halt_event), .bg_kick_count(bg_kick_count), .deferred_view(deferred_view)
  );
  hw_trigger_source src_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .flip_req(flip_req), .hw_pin(hw_trigger)
  );

  // ==========================================================
  // helpers
  // ==========================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // expected read word of a thread from the model
  function automatic logic [31:0] word(input int t);
    logic [15:0] s;
    s = tmr[t] | hwp;
    s[1] = (kq[t] != 0);
    s[3] = def_exc[t];
    return {kq[t][15:0], s & msk[t]};
  endfunction

  // request held until an edge that sees ready
  task automatic send(input logic w, input int t, input reg_sel_e s, input logic [31:0] d);
    logic r;
    @(posedge ref_clk);
    req <= '{1'b1, w, lv, t[1:0], s, d};
    r = 1'b0;
    for (int i = 0; i < 20 && !r; i++)
    begin
      @(negedge ref_clk);
      r = req_ready;
      @(posedge ref_clk);
    end
    req.valid <= 1'b0;
  endtask

  // bounded wait for the one-cycle answer
  task automatic get(input int lim);
    rd = 'x;
    ex = 1'bx;
    for (int i = 0; i < lim; i++)
    begin
      @(negedge ref_clk);
      if (rsp.valid === 1'b1)
      begin
        rd = rsp.rdata;
        ex = rsp.exc;
        break;
      end
    end
  endtask

  task automatic rd_op(input int t, input reg_sel_e s);
    send(1'b0, t, s, 32'h0);
    get(20);
  endtask

  // k kicks on back-to-back edges
  task automatic kick_n(input int t, input int k);
    @(posedge ref_clk);
    kick <= '{1'b1, LVL_BG, t[1:0]};
    repeat (k) @(posedge ref_clk);
    kick.valid <= 1'b0;
    kq[t] += k;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // watchdog
  initial
  begin
    #1_000_000;
    error_cnt++;
    test_done();
  end

  // ==========================================================
  // main sequence
  // ==========================================================
  initial
  begin
    void'($urandom(32'h6ec9));
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    bus_err_state <= $urandom;
    for (int t = 0; t < 4; t++)
    begin
      n = ($urandom & 32'hffff_000f) | (32'h100 << t);
      send(1'b1, t, SEL_MASK, n);
      msk[t] = n[15:0] & 16'hfffb;
      rd_op(t, SEL_MASK);
      check(rd, {16'h0000, msk[t]});
    end
    n = 1 + $urandom % 5;
    kick_n(0, n);
    kick_n(1, 2);
    send(1'b1, 0, SEL_MASK, 32'h0000_0007);
    msk[0] = 16'h0003;
    rd_op(0, SEL_MASK);
    check(rd, {16'h0000, msk[0]});
    @(posedge ref_clk);
    timer_event[0][0] <= 1'b1;
    halt_event[0] <= 1'b1;
    @(posedge ref_clk);
    timer_event[0][0] <= 1'b0;
    halt_event[0] <= 1'b0;
    tmr[0] = 16'h0001;
    check({16'h0, bg_kick_count[0]}, kq[0]);
    check({16'h0, bg_kick_count[1]}, kq[1]);
    // timer visible first, so the kick stays
    rd_op(0, SEL_STATUS);
    check(rd, word(0));
    check({16'h0, bg_kick_count[0]}, kq[0]);
    send(1'b1, 0, SEL_STATUS, 32'hffff_ffff);
    tmr[0] = 16'h0000;
    rd_op(0, SEL_POLL);
    check(rd, word(0));
    rd_op(0, SEL_POLL);
    check(rd, word(0));
    rd_op(0, SEL_STATUS);
    check(rd, word(0));
    kq[0]--;
    check({16'h0, bg_kick_count[0]}, kq[0]);
    // masked-off pin change kept, acknowledge ignored until enabled
    @(posedge ref_clk);
    flip_req[5] <= 1'b1;
    @(posedge ref_clk);
    flip_req[5] <= 1'b0;
    hwp[5] = 1'b1;
    repeat (6) @(posedge ref_clk);
    send(1'b1, 0, SEL_STATUS, 32'h0000_0020);
    send(1'b1, 0, SEL_MASK, 32'h0000_0023);
    msk[0] = 16'h0023;
    rd_op(0, SEL_POLL);
    check(rd, word(0));
    send(1'b1, 0, SEL_STATUS, 32'h0000_0020);
    hwp[5] = 1'b0;
    rd_op(0, SEL_POLL);
    check(rd, word(0));
    // parked read on thread 1 until its pin changes
    send(1'b1, 1, SEL_MASK, 32'h0000_0040);
    msk[1] = 16'h0040;
    send(1'b0, 1, SEL_STATUS, 32'h0);
    repeat (4)
    begin
      @(negedge ref_clk);
      check({31'h0, rsp.valid}, 32'h0);
    end
    @(posedge ref_clk);
    flip_req[6] <= 1'b1;
    @(posedge ref_clk);
    flip_req[6] <= 1'b0;
    hwp[6] = 1'b1;
    get(20);
    check(rd, word(1));
    // empty mask blocking read
    send(1'b1, 2, SEL_MASK, 32'h0);
    msk[2] = 16'h0000;
    rd_op(2, SEL_STATUS);
    check({31'h0, ex}, 32'h1);
    // deferred exception follows its level
    send(1'b1, 3, SEL_MASK, 32'h0000_0008);
    msk[3] = 16'h0008;
    @(posedge ref_clk);
    def_exc[3] <= 1'b1;
    rd_op(3, SEL_POLL);
    check(rd, word(3));
    @(posedge ref_clk);
    def_exc[3] <= 1'b0;
    rd_op(3, SEL_POLL);
    check(rd, word(3));
    // interrupt level keeps halt in its mask and its own pending bits
    lv = LVL_INT;
    send(1'b1, 0, SEL_MASK, 32'h0000_0007);
    rd_op(0, SEL_MASK);
    check(rd, 32'h0000_0007);
    rd_op(0, SEL_POLL);
    check(rd, 32'h0000_0004);
    rd_op(0, SEL_STATUS);
    check(rd, 32'h0000_0004);
    send(1'b1, 0, SEL_STATUS, 32'h0000_0004);
    rd_op(0, SEL_POLL);
    check(rd, 32'h0000_0000);
    lv = LVL_BG;
    // deferred flags for the checker and the bench model
    n = $urandom;
    @(posedge ref_clk);
    fp_event[0] <= n[5:0];
    bus_err_event[0] <= 1'b1;
    bus_err_state[0] <= n[15:8];
    @(posedge ref_clk);
    fp_event[0] <= '0;
    bus_err_event[0] <= 1'b0;
    repeat (4) @(negedge ref_clk);
    check({16'h0, deferred_view[0]}, {16'h0, n[15:8], 2'b10, n[5:0]});
    test_done();
  end
endmodule
`default_nettype wire
